// ### hdl/adc_seq_pkg.sv
// package: register map, field layout, reset values and phase codes of the conversion sequencer
package adc_seq_pkg;
  // register byte offsets on the ahb-lite bus
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;
  localparam logic [7:0] COUNT_OFS = 8'h0c;
  // control register fields
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 8;
  localparam int SAMP_LSB = 8;
  localparam int SAMP_W = 8;
  localparam int PCAL_BIT = 16;
  localparam int RES_LSB = 17;
  localparam int RES_W = 2;
  // control reset values
  localparam logic [7:0] DIV_RST = 8'h01;
  localparam logic [7:0] SAMP_RST = 8'h03;
  localparam logic PCAL_RST = 1'b1;
  localparam logic [1:0] RES_RST = 2'h1;
  // resolution codes and bit counts
  localparam logic [1:0] RES_8 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_12 = 2'h2;
  localparam int MAX_BITS = 12;
  // timing counts in converter clock periods; the divider multiplier is in system clocks
  localparam int CAL_CYCLES = 3840;
  localparam int SAMP_BASE = 2;
  localparam int PCAL_CYCLES = 2;
  localparam int DIV_MULT = 4;
  // ahb transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_READ = 3'b001,
    PH_SAMP = 3'b010,
    PH_DIST = 3'b011,
    PH_PCAL = 3'b100,
    PH_WRITE = 3'b101
  } phase_t;

  // software settings that steer the sequence
  typedef struct packed {
    logic [1:0] res;
    logic pcal_en;
    logic [7:0] samp;
    logic [7:0] div;
  } ctrl_t;
endpackage

// ### hdl/conv_clk_div.sv
// converter clock divider: one-cycle enable every 4*(1+setting) system clocks
`timescale 1ns/1ps
`default_nettype none
module conv_clk_div #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // divider setting and tick out
  input wire logic [DIV_W-1:0] div_set,
  output logic tick
);
  localparam int CNT_W = DIV_W + 3;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] reload;

  // reload value is period minus one; a new setting takes effect at the next wrap
  assign reload = CNT_W'(adc_seq_pkg::DIV_MULT * (int'(div_set) + 1) - 1);
  assign tick = (cnt_q == '0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= reload;
    end else begin
      cnt_q <= cnt_q - CNT_W'(1);
    end
  end
endmodule
`default_nettype wire

// ### hdl/adc_conv_seq.sv
// conversion sequencer: ahb-lite registers, calibration timer and phase machine
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module adc_conv_seq #(
  parameter int RES_MAX = adc_seq_pkg::MAX_BITS
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // fabric controller
  input wire logic CONV_START,
  output logic CONV_DONE,
  output logic [RES_MAX-1:0] CONV_RESULT,
  output logic CAL_BUSY,
  // analog converter
  input wire logic COMP_IN,
  output logic SAMPLE_HOLD,
  output logic [RES_MAX-1:0] DAC_CODE
);
  adc_seq_pkg::ctrl_t ctrl_q;
  adc_seq_pkg::phase_t st_q;
  adc_seq_pkg::phase_t st_d;
  logic tick;
  logic [1:0] comp_sync_q;
  logic comp_s;
  logic [11:0] cal_cnt_q;
  logic [8:0] cnt_q;
  logic [3:0] idx_q;
  logic [RES_MAX-1:0] sar_q;
  logic [RES_MAX-1:0] result_q;
  logic done_q;
  logic [15:0] done_cnt_q;
  logic [8:0] samp_len;
  logic [3:0] nbits;
  logic cnt_last;

  // ahb address phase capture
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  wire addr_ok = HSEL && HREADY && (HTRANS == adc_seq_pkg::HTRANS_NONSEQ);
  wire rd_take = addr_ok && !HWRITE;
  wire wr_take = addr_ok && HWRITE;
  wire [7:0] a_ofs = HADDR[7:0];
  wire hit_ctrl = (a_ofs == adc_seq_pkg::CTRL_OFS);
  wire hit_stat = (a_ofs == adc_seq_pkg::STATUS_OFS);
  wire hit_res = (a_ofs == adc_seq_pkg::RESULT_OFS);
  wire hit_cnt = (a_ofs == adc_seq_pkg::COUNT_OFS);
  wire wr_ctrl = wr_pend_q && (wr_addr_q == adc_seq_pkg::CTRL_OFS);
  wire [31:0] ctrl_word = {13'h0000, ctrl_q};
  wire [31:0] stat_word = {27'h0000000, st_q, CAL_BUSY, (st_q != adc_seq_pkg::PH_IDLE)};
  wire [31:0] res_word = {{(32-RES_MAX){1'b0}}, result_q};
  wire [31:0] cnt_word = {16'h0000, done_cnt_q};
  logic [31:0] rd_mux;

  // read decode, unmapped offsets read zero
  always_comb begin
    if (hit_ctrl) begin
      rd_mux = ctrl_word;
    end else if (hit_stat) begin
      rd_mux = stat_word;
    end else if (hit_res) begin
      rd_mux = res_word;
    end else if (hit_cnt) begin
      rd_mux = cnt_word;
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // zero wait states: every transfer completes OKAY in its first data cycle
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_q;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= wr_take;
      wr_addr_q <= a_ofs;
      rdata_q <= rd_take ? rd_mux : 32'h00000000;
    end
  end

  // control register; a change mid-conversion applies to the remaining phases
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_q <= '{res: adc_seq_pkg::RES_RST, pcal_en: adc_seq_pkg::PCAL_RST,
                  samp: adc_seq_pkg::SAMP_RST, div: adc_seq_pkg::DIV_RST};
    end else if (wr_ctrl) begin
      ctrl_q <= HWDATA[18:0];
    end
  end

  // converter clock enable
  conv_clk_div #(.DIV_W(adc_seq_pkg::DIV_W)) u_div (
    .clk(CLK),
    .rst_n(RST_N),
    .div_set(ctrl_q.div),
    .tick(tick)
  );

  // comparator comes from the analog side, so it is synchronised first
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      comp_sync_q <= 2'b00;
    end else begin
      comp_sync_q <= {comp_sync_q[0], COMP_IN};
    end
  end
  assign comp_s = comp_sync_q[1];

  // power-up calibration counts converter clocks only, so starts cannot stretch it
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cal_cnt_q <= 12'h000;
    end else if (CAL_BUSY && tick) begin
      cal_cnt_q <= cal_cnt_q + 12'h001;
    end
  end
  assign CAL_BUSY = (cal_cnt_q != 12'(adc_seq_pkg::CAL_CYCLES));

  // phase lengths
  assign samp_len = 9'(adc_seq_pkg::SAMP_BASE) + {1'b0, ctrl_q.samp};
  assign nbits = (ctrl_q.res == adc_seq_pkg::RES_8) ? 4'h8 :
                 (ctrl_q.res == adc_seq_pkg::RES_12) ? 4'hc : 4'ha;
  assign cnt_last = tick && (cnt_q == samp_len - 9'h001);

  // phase machine; a start in any phase wins over the normal step
  always_comb begin
    st_d = st_q;
    case (st_q)
      adc_seq_pkg::PH_IDLE: st_d = adc_seq_pkg::PH_IDLE;
      adc_seq_pkg::PH_READ: st_d = adc_seq_pkg::PH_SAMP;
      adc_seq_pkg::PH_SAMP: begin
        if (cnt_last) st_d = adc_seq_pkg::PH_DIST;
      end
      adc_seq_pkg::PH_DIST: begin
        if (tick && idx_q == 4'h0) begin
          st_d = ctrl_q.pcal_en ? adc_seq_pkg::PH_PCAL : adc_seq_pkg::PH_WRITE;
        end
      end
      adc_seq_pkg::PH_PCAL: begin
        if (tick && cnt_q == 9'(adc_seq_pkg::PCAL_CYCLES - 1)) st_d = adc_seq_pkg::PH_WRITE;
      end
      adc_seq_pkg::PH_WRITE: st_d = adc_seq_pkg::PH_IDLE;
      default: st_d = adc_seq_pkg::PH_IDLE;
    endcase
    if (CONV_START) st_d = adc_seq_pkg::PH_READ;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_q <= adc_seq_pkg::PH_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // phase counter clears on every phase change
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cnt_q <= 9'h000;
    end else if (st_d != st_q || CONV_START) begin
      cnt_q <= 9'h000;
    end else if (tick) begin
      cnt_q <= cnt_q + 9'h001;
    end
  end

  // successive approximation, msb first, one bit per converter clock
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sar_q <= '0;
      idx_q <= 4'h0;
    end else if (st_d == adc_seq_pkg::PH_DIST && st_q != adc_seq_pkg::PH_DIST) begin
      sar_q <= '0;
      idx_q <= nbits - 4'h1;
    end else if (st_q == adc_seq_pkg::PH_DIST && tick) begin
      sar_q[idx_q] <= comp_s;
      idx_q <= (idx_q == 4'h0) ? 4'h0 : idx_q - 4'h1;
    end
  end

  // trial code and hold control toward the analog core
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      DAC_CODE <= '0;
      SAMPLE_HOLD <= 1'b0;
    end else begin
      DAC_CODE <= (st_q == adc_seq_pkg::PH_DIST) ? (sar_q | (RES_MAX'(1) << idx_q)) : sar_q;
      SAMPLE_HOLD <= (st_d == adc_seq_pkg::PH_SAMP);
    end
  end

  // result and done leave only from the write phase; an abandoned one gives nothing
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      done_q <= 1'b0;
      result_q <= '0;
      done_cnt_q <= 16'h0000;
    end else begin
      done_q <= (st_q == adc_seq_pkg::PH_WRITE) && !CONV_START;
      if (st_q == adc_seq_pkg::PH_WRITE && !CONV_START) begin
        result_q <= sar_q;
        done_cnt_q <= done_cnt_q + 16'h0001;
      end
    end
  end
  assign CONV_DONE = done_q;
  assign CONV_RESULT = result_q;

  // helper: system clocks since the previous converter tick, and the divider it reloaded with;
  // a divider write only shapes the period after the next wrap, so the check uses that copy
  logic [11:0] gap_q;
  logic seen_q;
  logic [adc_seq_pkg::DIV_W-1:0] div_tick_q;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      gap_q <= 12'h000;
      seen_q <= 1'b0;
      div_tick_q <= adc_seq_pkg::DIV_RST;
    end else begin
      gap_q <= tick ? 12'h001 : gap_q + 12'h001;
      seen_q <= seen_q | tick;
      div_tick_q <= tick ? ctrl_q.div : div_tick_q;
    end
  end

  sequence s_write_clean;
    (st_q == adc_seq_pkg::PH_WRITE) && !CONV_START;
  endsequence
  sequence s_done_pulse;
    CONV_DONE ##1 !CONV_DONE;
  endsequence

  property p_start_restart;
    @(posedge CLK) disable iff (!RST_N)
      CONV_START |=> (st_q == adc_seq_pkg::PH_READ) && !CONV_DONE;
  endproperty
  a_start_restart: assert property (p_start_restart) else $error("start not taken");

  property p_order_read;
    @(posedge CLK) disable iff (!RST_N)
      (st_q == adc_seq_pkg::PH_READ) && !CONV_START |=> (st_q == adc_seq_pkg::PH_SAMP);
  endproperty
  a_order_read: assert property (p_order_read) else $error("read not followed by sample");

  property p_samp_len;
    @(posedge CLK) disable iff (!RST_N)
      (st_q == adc_seq_pkg::PH_SAMP) && (st_d == adc_seq_pkg::PH_DIST)
        |-> (cnt_q == 9'(ctrl_q.samp) + 9'h001);
  endproperty
  a_samp_len: assert property (p_samp_len) else $error("sample length wrong");

  property p_dist_bits;
    @(posedge CLK) disable iff (!RST_N)
      (st_q == adc_seq_pkg::PH_DIST) && !CONV_START && (st_d != adc_seq_pkg::PH_DIST)
        |-> (cnt_q == 9'(nbits) - 9'h001);
  endproperty
  a_dist_bits: assert property (p_dist_bits) else $error("bit count wrong");

  property p_pcal;
    @(posedge CLK) disable iff (!RST_N)
      (st_q == adc_seq_pkg::PH_PCAL) |-> ctrl_q.pcal_en || $past(st_q) == adc_seq_pkg::PH_PCAL;
  endproperty
  a_pcal: assert property (p_pcal) else $error("post-cal without enable");

  property p_cal_len;
    @(posedge CLK) disable iff (!RST_N)
      $fell(CAL_BUSY) |-> $past(cal_cnt_q) == 12'(adc_seq_pkg::CAL_CYCLES - 1) && $past(tick);
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");

  property p_tick_gap;
    @(posedge CLK) disable iff (!RST_N)
      tick && seen_q
        |-> gap_q == 12'(adc_seq_pkg::DIV_MULT * (int'(div_tick_q) + 1));
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("converter period wrong");

  property p_done;
    @(posedge CLK) disable iff (!RST_N)
      s_write_clean |=> s_done_pulse;
  endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");

  property p_done_cause;
    @(posedge CLK) disable iff (!RST_N)
      CONV_DONE |-> $past(st_q) == adc_seq_pkg::PH_WRITE && CONV_RESULT == $past(sar_q);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("spurious done");
endmodule
`default_nettype wire

// ### verif/conv_ctrl_model.sv
// fabric controller model: legal one-cycle start pulses and an ideal comparator
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request from the bench, start pulse to the sequencer
  input wire logic req,
  output logic start,
  // comparator side
  input wire logic [11:0] dac_code,
  input wire logic [11:0] level,
  output logic comp
);
  // a request right after a pulse is dropped, so pulses never sit closer than two cycles
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start <= 1'b0;
    end else begin
      start <= req & ~start;
    end
  end
  // ideal comparator: high while the trial code does not exceed the input level
  assign comp = (dac_code <= level);
endmodule
`default_nettype wire

// ### verif/adc_conversion_sequencer_bench.sv
// bench for the conversion sequencer: registers, calibration, timed and injected conversions
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_bench;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, start, done, cal_busy, comp, sh, req, p;
  logic [1:0] htrans, r;
  logic [2:0] hsize;
  logic [7:0] d, s;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [11:0] result, dac, level;
  int n_errors, checked, cyc, t_start, t_done, t_cal, n_done, sh_cnt, exp_cnt;

  adc_conv_seq DUT (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .CONV_START(start), .CONV_DONE(done),
    .CONV_RESULT(result), .CAL_BUSY(cal_busy), .COMP_IN(comp), .SAMPLE_HOLD(sh), .DAC_CODE(dac));
  conv_ctrl_model partner (.clk(clk), .rst_n(rst_n), .req(req), .start(start),
    .dac_code(dac), .level(level), .comp(comp));

  // 125 MHz system clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // monitor: cycle stamps of starts, completions, end of calibration and sample width
  always @(posedge clk) begin
    if (!rst_n) begin
      cyc = 0;
      t_cal = 0;
    end else begin
      cyc = cyc + 1;
      if (start === 1'b1) begin
        t_start = cyc;
        sh_cnt = 0;
      end
      if (done === 1'b1) begin
        t_done = cyc;
        n_done++;
      end
      if (sh === 1'b1) sh_cnt++;
      if (cal_busy === 1'b0 && t_cal == 0) t_cal = cyc;
    end
  end

  function automatic int nbits(input logic [1:0] rs);
    return rs == adc_seq_pkg::RES_8 ? 8 : (rs == adc_seq_pkg::RES_12 ? 12 : 10);
  endfunction

  // ideal comparator: the approximation settles on the level, clipped to the full-scale code
  function automatic logic [11:0] exp_res(input logic [11:0] lv, input logic [1:0] rs);
    int top;
    top = (1 << nbits(rs)) - 1;
    return (int'(lv) > top) ? 12'(top) : lv;
  endfunction

  // free-running divider: the first tick may land anywhere in one converter period
  function automatic logic lat_ok(input int lat, input logic [7:0] dv, sv, input logic pv,
                                  input logic [1:0] rs);
    int pp, t;
    pp = adc_seq_pkg::DIV_MULT * (1 + int'(dv));
    t = adc_seq_pkg::SAMP_BASE + int'(sv) + nbits(rs) + adc_seq_pkg::PCAL_CYCLES * int'(pv);
    return lat >= (t - 1) * pp + 2 && lat <= t * pp + 5;
  endfunction

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // one single ahb-lite transfer; entered just after a rising edge
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= adc_seq_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(what, rd, exp);
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task go;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
  endtask

  task wait_done(input int target);
    int k;
    k = 0;
    while (n_done < target && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k == 3000) check("done wait", 32'h0, 32'h1);
  endtask

  task close_out;
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // watchdog sized well above calibration plus all conversions
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    close_out;
  end

  // main sequence
  initial begin
    rst_n = 1'b0; hsel = 1'b0; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = 32'h0; req = 1'b0; level = 12'h5a3; n_errors = 0; checked = 0; n_done = 0;
    exp_cnt = 0; t_cal = 0; cyc = 0; t_start = 0; t_done = 0; sh_cnt = 0;
    void'($urandom(32'h8497));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("cal busy", {31'h0, cal_busy}, 32'h1);
    rchk("ctrl reset", adc_seq_pkg::CTRL_OFS, 32'h00030301);
    rchk("status reset", adc_seq_pkg::STATUS_OFS, 32'h2);
    rchk("unmapped", 8'h40, 32'h0);
    // fastest converter clock; a conversion inside calibration must not stretch it
    ahb(1'b1, adc_seq_pkg::CTRL_OFS, 32'h00030300);
    go;
    wait_done(1);
    exp_cnt = 1;
    while (t_cal == 0 && cyc < 20000) @(posedge clk);
    check("cal length", {31'h0, t_cal >= 15352 && t_cal <= 15376}, 32'h1);
    // every resolution code first, then random settings
    for (int i = 0; i < 8; i++) begin
      d = (i < 4) ? 8'h0 : 8'($urandom % 4);
      s = 8'($urandom % 8);
      p = (i < 4) ? 1'(i % 2) : 1'($urandom % 2);
      r = (i < 4) ? 2'(i) : 2'($urandom % 3);
      level <= 12'($urandom);
      ahb(1'b1, adc_seq_pkg::CTRL_OFS, {13'h0, r, p, s, d});
      rchk("ctrl", adc_seq_pkg::CTRL_OFS, {13'h0, r, p, s, d});
      // let the divider wrap once so the new period is in force before the start
      repeat (16) @(posedge clk);
      go;
      wait_done(exp_cnt + 1);
      exp_cnt++;
      check("latency", {31'h0, lat_ok(t_done - t_start, d, s, p, r)}, 32'h1);
      check("sample span", {31'h0, sh_cnt >= (1 + s) * 4 * (1 + d) &&
        sh_cnt <= (2 + s) * 4 * (1 + d) + 1}, 32'h1);
      check("result width", {20'h0, result >> nbits(r)}, 32'h0);
      check("result", {20'h0, result}, {20'h0, exp_res(level, r)});
      rchk("count", adc_seq_pkg::COUNT_OFS, exp_cnt);
    end
    // injected conversions at the minimum spacing and near the end of the sample phase
    for (int g = 2; g <= 20; g += 18) begin
      ahb(1'b1, adc_seq_pkg::CTRL_OFS, 32'h00030300);
      repeat (16) @(posedge clk);
      go;
      repeat (g - 1) @(posedge clk);
      go;
      wait_done(exp_cnt + 1);
      repeat (40) @(posedge clk);
      check("dropped done", n_done, exp_cnt + 1);
      exp_cnt++;
      check("injected latency", {31'h0, lat_ok(t_done - t_start, 0, 3, 1, 1)}, 32'h1);
      check("injected result", {20'h0, result}, {20'h0, exp_res(level, 2'h1)});
    end
    ahb(1'b1, adc_seq_pkg::COUNT_OFS, 32'hffff);
    rchk("count ro", adc_seq_pkg::COUNT_OFS, exp_cnt);
    rchk("status idle", adc_seq_pkg::STATUS_OFS, 32'h0);
    close_out;
  end
endmodule
`default_nettype wire
